// ### design/hsq_pkg.sv
// Package: register map, field layout, states and timing constants of the homing sequencer
package hsq_pkg;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL       = 8'h00;
   localparam logic [7:0] OFS_TYPE       = 8'h04;
   localparam logic [7:0] OFS_HOME_SPEED = 8'h08;
   localparam logic [7:0] OFS_CREEP      = 8'h0C;
   localparam logic [7:0] OFS_SHIFT      = 8'h10;
   localparam logic [7:0] OFS_HOME_RAMP  = 8'h14;
   localparam logic [7:0] OFS_HOME_POS   = 8'h18;
   localparam logic [7:0] OFS_POST_DOG   = 8'h1C;
   localparam logic [7:0] OFS_FILTER     = 8'h20;
   localparam logic [7:0] OFS_NORM_RAMP  = 8'h24;
   localparam logic [7:0] OFS_PROG_MASK  = 8'h28;
   localparam logic [7:0] OFS_STATUS     = 8'h2C;
   localparam logic [7:0] OFS_POSITION   = 8'h30;

   // Field positions
   localparam int CTRL_PROG_BIT   = 0;   // 1: program method, 0: table method
   localparam int CTRL_START_BIT  = 1;   // Write 1: software start
   localparam int TYPE_KIND_LSB   = 0;   // Lowest hex digit: homing kind
   localparam int TYPE_DIR_LSB    = 4;   // Second digit: start direction
   localparam int TYPE_POL_LSB    = 8;   // Third digit: dog polarity
   localparam int STAT_BUSY_BIT   = 0;
   localparam int STAT_DONE_BIT   = 1;   // Sticky, write 1 to clear
   localparam int STAT_STATE_LSB  = 2;
   localparam int STAT_MODE_BIT   = 5;
   localparam int STAT_TERR_BIT   = 6;

   // Homing kinds
   localparam logic [3:0] KIND_DOG   = 4'h0;
   localparam logic [3:0] KIND_COUNT = 4'h1;

   // Reset values
   localparam logic [31:0] RST_ZERO   = 32'h0000_0000;
   localparam logic [15:0] RST_FILTER = 16'h0003;

   // Discrete input slots
   localparam int IN_AUTO  = 0;
   localparam int IN_TBL0  = 1;
   localparam int IN_DOG   = 4;
   localparam int IN_START = 5;
   localparam int IN_Z     = 6;
   localparam int IN_STEP  = 7;
   localparam int IN_EDIR  = 8;
   localparam int IN_NUM   = 9;
   localparam int IN_SLOW  = 6;          // Slots below this are filtered

   // Timing
   localparam int CLK_PERIOD_PS = 4000;
   localparam int FILT_UNIT_NS  = 1000000;   // Filter counts in 1 ms units
   localparam int FILT_UNIT_CYC = FILT_UNIT_NS * 1000 / CLK_PERIOD_PS;
   localparam int DOG_MIN_MS    = 10;

   // Sequencer states, Gray coded along the search path
   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,
      ST_FAST  = 3'h1,
      ST_CREEP = 3'h3,
      ST_WAITZ = 3'h2,
      ST_SHIFT = 3'h6,
      ST_DONE  = 3'h7
   } hsq_state_t;

endpackage

// ### design/hsq_in_filter.sv
// One discrete input: three-stage synchroniser and persistence filter
`timescale 1ns/1ps
module hsq_in_filter (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // Filter control
   input  wire logic        tick_en,
   input  wire logic [15:0] filt_len,
   // Pin and result
   input  wire logic        pin,
   output logic             level
);
   logic        sync1;
   logic        sync2;
   logic        sync3;
   logic [15:0] cnt;
   logic [15:0] next_cnt;
   logic        next_level;

   // Change is seen once stages two and three agree; then it must persist
   always_comb begin
      next_cnt   = cnt;
      next_level = level;
      if (sync2 == sync3 && sync3 != level) begin
         if (cnt >= filt_len) begin
            next_level = sync3;
            next_cnt   = 16'h0000;
         end else if (tick_en) begin
            next_cnt = cnt + 16'h0001;
         end
      end else begin
         next_cnt = 16'h0000;
      end
   end

   // Registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
         sync3 <= 1'b0;
         cnt   <= 16'h0000;
         level <= 1'b0;
      end else begin
         sync1 <= pin;
         sync2 <= sync1;
         sync3 <= sync2;
         cnt   <= next_cnt;
         level <= next_level;
      end
   end
endmodule // hsq_in_filter

// ### design/hsq_homing_sequencer.sv
// Home-return sequencer with APB registers, input filters and dog/count search
//
// What this block does
// R01: The host holds auto/manual select on and all three table bits off to pick home return.
// R02: In program method a selected program marked as holding the return-home command starts it.
// R03: A homing kind digit of zero runs the dog-type search.
// R04: From start until the dog is seen the axis runs at the homing speed.
// R05: After the dog is seen the axis runs at the creep speed.
// R06: Deceleration starts at the dog front edge and home is the first index after the rear edge.
// R07: A nonzero shift distance puts home that far beyond the index.
// R08: During home return the homing ramp time is used instead of the normal ramp.
// R09: On completion the current position is loaded with the home position value.
// R10: Each discrete input is recognised only after persisting for the filter time; here the index and encoder slots (IN_SLOW and up) only synchronise.
// R11: The host settles the table bits early enough to cover its own latency.
// R12: In count type the axis travels the post-dog distance, then the next index is home.
// R13: In count type a dog pulse of at least the minimum length suffices, dog length aside.
// R14: Direction 0 starts toward increasing addresses, 1 toward decreasing.
// R15: Polarity 0 detects the dog when its input is off, 1 when it is on.
// R16: The index pulse is used inside only and never driven out.
// R17: When home is fixed motion stops, the sequence ends and completion is shown.
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module hsq_homing_sequencer #(
   parameter int TICK_CYC = hsq_pkg::FILT_UNIT_CYC
) (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Discrete inputs from the host
   input  wire logic        auto_manual_select,
   input  wire logic        table_select_bit0,
   input  wire logic        table_select_bit1,
   input  wire logic        table_select_bit2,
   input  wire logic        start_request,
   // Sensors
   input  wire logic        dog_pin,
   input  wire logic        z_index,
   input  wire logic        enc_step,
   input  wire logic        enc_down,
   // Motion command
   output logic             move_en,
   output logic             move_dir,
   output logic [31:0]      speed_cmd,
   output logic [31:0]      ramp_time,
   output logic             homing_busy,
   output logic             home_done
);
   // Registers
   logic        prog_method;
   logic [15:0] homing_type_param;
   logic [31:0] homing_speed_param;
   logic [31:0] creep_speed_param;
   logic [31:0] home_shift_param;
   logic [31:0] homing_ramp_param;
   logic [31:0] home_position_value_param;
   logic [31:0] post_dog_travel_param;
   logic [15:0] input_filter_param;
   logic [31:0] normal_ramp;
   logic [7:0]  return_home_command;
   logic [31:0] cur_pos;
   logic        done_flag;
   hsq_pkg::hsq_state_t state;
   hsq_pkg::hsq_state_t next_state;
   logic [31:0] travel;
   logic [31:0] next_travel;
   logic        dog_prev;
   logic        z_prev;
   logic        step_prev;
   logic        start_prev;
   logic [31:0] next_pos;
   logic        next_done;
   logic        next_move_en;
   logic [31:0] next_speed;
   // Filter tick
   logic [17:0] tick_cnt;
   logic        tick_en;
   // Filtered inputs
   logic [hsq_pkg::IN_NUM-1:0] pins;
   logic [hsq_pkg::IN_NUM-1:0] lvl;
   // Decode
   logic        wr_en;
   logic        sw_start;
   logic [2:0]  tbl;
   logic [3:0]  kind;
   logic        type_ok;
   logic        mode_sel;
   logic        dog_act;
   logic        z_rise;
   logic        step_rise;
   logic        start_go;
   logic        is_count;

   assign pins = {enc_down, enc_step, z_index, start_request, dog_pin,
                  table_select_bit2, table_select_bit1, table_select_bit0,
                  auto_manual_select};

   // Millisecond tick for the persistence filters
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         tick_cnt <= 18'h00000;
      end else if (tick_cnt == 18'(TICK_CYC - 1)) begin
         tick_cnt <= 18'h00000;
      end else begin
         tick_cnt <= tick_cnt + 18'h00001;
      end
   end
   assign tick_en = (tick_cnt == 18'(TICK_CYC - 1));

   // Slow host inputs get the filter time; index and encoder only synchronise
   for (genvar i = 0; i < hsq_pkg::IN_NUM; i++) begin : g_in
      hsq_in_filter u_filt (
         .ref_clk  (ref_clk),
         .rst      (rst),
         .tick_en  (tick_en),
         .filt_len ((i < hsq_pkg::IN_SLOW) ? input_filter_param : 16'h0000), // R10
         .pin      (pins[i]),
         .level    (lvl[i])
      );
   end

   // Mode selection and start qualification
   assign tbl      = lvl[hsq_pkg::IN_TBL0 +: 3];
   assign kind     = homing_type_param[hsq_pkg::TYPE_KIND_LSB +: 4];
   assign is_count = (kind == hsq_pkg::KIND_COUNT);
   assign type_ok  = (kind == hsq_pkg::KIND_DOG) || is_count;
   assign mode_sel = lvl[hsq_pkg::IN_AUTO] &&
                     (prog_method ? return_home_command[tbl]  // R02
                                  : (tbl == 3'h0));           // R01
   assign wr_en    = psel && penable && pwrite;
   assign sw_start = wr_en && paddr == hsq_pkg::OFS_CTRL &&
                     pwdata[hsq_pkg::CTRL_START_BIT];
   assign start_go = (state == hsq_pkg::ST_IDLE) && mode_sel && type_ok &&
                     ((lvl[hsq_pkg::IN_START] && !start_prev) || sw_start);
   // Dog level honours the polarity digit
   assign dog_act  = homing_type_param[hsq_pkg::TYPE_POL_LSB] ? lvl[hsq_pkg::IN_DOG]
                                                              : !lvl[hsq_pkg::IN_DOG]; // R15
   assign z_rise    = lvl[hsq_pkg::IN_Z] && !z_prev;      // R16
   assign step_rise = lvl[hsq_pkg::IN_STEP] && !step_prev;

   // Sequencer next state, travel count, position and outputs
   always_comb begin
      next_state   = state;
      next_travel  = travel;
      next_pos     = cur_pos;
      next_done    = done_flag;
      next_move_en = 1'b0;
      next_speed   = 32'h0000_0000;
      if (step_rise) begin
         next_pos = lvl[hsq_pkg::IN_EDIR] ? cur_pos - 32'h0000_0001
                                          : cur_pos + 32'h0000_0001;
      end
      case (state)
         hsq_pkg::ST_IDLE: begin
            if (start_go) begin
               next_state = hsq_pkg::ST_FAST; // R03
            end
         end
         hsq_pkg::ST_FAST: begin
            if (dog_act) begin
               next_state  = hsq_pkg::ST_CREEP; // R06
               next_travel = 32'h0000_0000;
            end
         end
         hsq_pkg::ST_CREEP: begin
            if (step_rise) begin
               next_travel = travel + 32'h0000_0001;
            end
            if (is_count) begin
               // Dog ignored once its front edge was taken; short dogs are fine
               if (travel >= post_dog_travel_param) begin
                  next_state = hsq_pkg::ST_WAITZ; // R12 R13
               end
            end else if (dog_prev && !dog_act) begin
               next_state = hsq_pkg::ST_WAITZ; // R06
            end
         end
         hsq_pkg::ST_WAITZ: begin
            if (z_rise) begin
               next_travel = 32'h0000_0000;
               next_state  = (home_shift_param == 32'h0000_0000) ? hsq_pkg::ST_DONE
                                                                 : hsq_pkg::ST_SHIFT; // R07
            end
         end
         hsq_pkg::ST_SHIFT: begin
            if (step_rise) begin
               next_travel = travel + 32'h0000_0001;
            end
            if (travel >= home_shift_param) begin
               next_state = hsq_pkg::ST_DONE; // R07
            end
         end
         hsq_pkg::ST_DONE: begin
            next_pos   = home_position_value_param; // R09
            next_done  = 1'b1;                      // R17
            next_state = hsq_pkg::ST_IDLE;          // R17
         end
         default: begin
            next_state = hsq_pkg::ST_IDLE;
         end
      endcase
      // Set wins over a software clear in the same cycle
      if (wr_en && paddr == hsq_pkg::OFS_STATUS && pwdata[hsq_pkg::STAT_DONE_BIT] &&
          state != hsq_pkg::ST_DONE) begin
         next_done = 1'b0;
      end
      if (start_go) begin
         next_done = 1'b0;
      end
      // Outputs follow the next state so they line up with it
      case (next_state)
         hsq_pkg::ST_FAST: begin
            next_move_en = 1'b1;
            next_speed   = homing_speed_param; // R04
         end
         hsq_pkg::ST_CREEP, hsq_pkg::ST_WAITZ, hsq_pkg::ST_SHIFT: begin
            next_move_en = 1'b1;
            next_speed   = creep_speed_param; // R05
         end
         default: begin
            next_move_en = 1'b0; // R17
         end
      endcase
   end

   // Sequencer registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state      <= hsq_pkg::ST_IDLE;
         travel     <= hsq_pkg::RST_ZERO;
         cur_pos    <= hsq_pkg::RST_ZERO;
         done_flag  <= 1'b0;
         dog_prev   <= 1'b0;
         z_prev     <= 1'b0;
         step_prev  <= 1'b0;
         start_prev <= 1'b0;
         move_en    <= 1'b0;
         speed_cmd  <= hsq_pkg::RST_ZERO;
      end else begin
         state      <= next_state;
         travel     <= next_travel;
         cur_pos    <= next_pos;
         done_flag  <= next_done;
         dog_prev   <= dog_act;
         z_prev     <= lvl[hsq_pkg::IN_Z];
         step_prev  <= lvl[hsq_pkg::IN_STEP];
         start_prev <= lvl[hsq_pkg::IN_START];
         move_en    <= next_move_en;
         speed_cmd  <= next_speed;
      end
   end

   // Direction and ramp selection are steady while a search runs
   assign move_dir    = homing_type_param[hsq_pkg::TYPE_DIR_LSB]; // R14
   assign homing_busy = (state != hsq_pkg::ST_IDLE);
   assign ramp_time   = homing_busy ? homing_ramp_param : normal_ramp; // R08
   assign home_done   = done_flag; // R17

   // APB: zero wait states; read data captured in the setup cycle
   assign pready  = 1'b1;
   assign pslverr = psel && penable && (paddr > hsq_pkg::OFS_POSITION || paddr[1:0] != 2'h0);

   // Register writes and read capture
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         prog_method               <= 1'b0;
         homing_type_param         <= hsq_pkg::RST_ZERO[15:0];
         homing_speed_param        <= hsq_pkg::RST_ZERO;
         creep_speed_param         <= hsq_pkg::RST_ZERO;
         home_shift_param          <= hsq_pkg::RST_ZERO;
         homing_ramp_param         <= hsq_pkg::RST_ZERO;
         home_position_value_param <= hsq_pkg::RST_ZERO;
         post_dog_travel_param     <= hsq_pkg::RST_ZERO;
         input_filter_param        <= hsq_pkg::RST_FILTER;
         normal_ramp               <= hsq_pkg::RST_ZERO;
         return_home_command       <= hsq_pkg::RST_ZERO[7:0];
         prdata                    <= hsq_pkg::RST_ZERO;
      end else begin
         if (wr_en) begin
            case (paddr)
               hsq_pkg::OFS_CTRL:       prog_method <= pwdata[hsq_pkg::CTRL_PROG_BIT];
               hsq_pkg::OFS_TYPE:       homing_type_param <= pwdata[15:0];
               hsq_pkg::OFS_HOME_SPEED: homing_speed_param <= pwdata;
               hsq_pkg::OFS_CREEP:      creep_speed_param <= pwdata;
               hsq_pkg::OFS_SHIFT:      home_shift_param <= pwdata;
               hsq_pkg::OFS_HOME_RAMP:  homing_ramp_param <= pwdata;
               hsq_pkg::OFS_HOME_POS:   home_position_value_param <= pwdata;
               hsq_pkg::OFS_POST_DOG:   post_dog_travel_param <= pwdata;
               hsq_pkg::OFS_FILTER:     input_filter_param <= pwdata[15:0];
               hsq_pkg::OFS_NORM_RAMP:  normal_ramp <= pwdata;
               hsq_pkg::OFS_PROG_MASK:  return_home_command <= pwdata[7:0];
               default: begin
               end
            endcase
         end
         if (psel && !penable) begin
            case (paddr)
               hsq_pkg::OFS_CTRL:       prdata <= {31'h0, prog_method};
               hsq_pkg::OFS_TYPE:       prdata <= {16'h0, homing_type_param};
               hsq_pkg::OFS_HOME_SPEED: prdata <= homing_speed_param;
               hsq_pkg::OFS_CREEP:      prdata <= creep_speed_param;
               hsq_pkg::OFS_SHIFT:      prdata <= home_shift_param;
               hsq_pkg::OFS_HOME_RAMP:  prdata <= homing_ramp_param;
               hsq_pkg::OFS_HOME_POS:   prdata <= home_position_value_param;
               hsq_pkg::OFS_POST_DOG:   prdata <= post_dog_travel_param;
               hsq_pkg::OFS_FILTER:     prdata <= {16'h0, input_filter_param};
               hsq_pkg::OFS_NORM_RAMP:  prdata <= normal_ramp;
               hsq_pkg::OFS_PROG_MASK:  prdata <= {24'h0, return_home_command};
               hsq_pkg::OFS_STATUS:     prdata <= {25'h0, !type_ok, mode_sel, state,
                                                   done_flag, homing_busy};
               hsq_pkg::OFS_POSITION:   prdata <= cur_pos;
               default:                 prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   sequence seq_finished;
      state == hsq_pkg::ST_IDLE && !move_en && home_done;
   endsequence

   chk_start_fast: assert property (start_go |=> state == hsq_pkg::ST_FAST && move_en) // R03
      else $error("start did not enter fast search");
   chk_fast_speed: assert property (state == hsq_pkg::ST_FAST |-> speed_cmd == homing_speed_param) // R04
      else $error("fast search not at homing speed");
   chk_creep_speed: assert property (state == hsq_pkg::ST_CREEP && $stable(creep_speed_param) |-> speed_cmd == creep_speed_param) // R05
      else $error("creep not at creep speed");
   chk_dog_front: assert property (state == hsq_pkg::ST_FAST && dog_act |=> state == hsq_pkg::ST_CREEP) // R06
      else $error("dog front edge missed");
   chk_dog_rear: assert property (state == hsq_pkg::ST_CREEP && !is_count && dog_prev && !dog_act |=> state == hsq_pkg::ST_WAITZ) // R06
      else $error("dog rear edge missed");
   chk_shift_entry: assert property (state == hsq_pkg::ST_WAITZ && z_rise && home_shift_param != 32'h0 |=> state == hsq_pkg::ST_SHIFT) // R07
      else $error("shift not entered after index");
   chk_ramp_select: assert property (homing_busy |-> ramp_time == homing_ramp_param) // R08
      else $error("homing ramp not applied");
   chk_pos_load: assert property (state == hsq_pkg::ST_DONE |=> cur_pos == $past(home_position_value_param)) // R09
      else $error("position not loaded at home");
   chk_count_travel: assert property (state == hsq_pkg::ST_CREEP && is_count && travel >= post_dog_travel_param |=> state == hsq_pkg::ST_WAITZ) // R12
      else $error("count travel did not end");
   chk_done_stop: assert property (state == hsq_pkg::ST_DONE |=> seq_finished) // R17
      else $error("completion did not stop motion");
endmodule // hsq_homing_sequencer

// ### verif/hsq_axis_model.sv
// Axis and sensor model: encoder steps, index pulse and proximity dog
`timescale 1ns/1ps
module hsq_axis_model #(
   parameter int STEP_CYC = 8,
   parameter int DOG_LO   = 40,
   parameter int DOG_HI   = 80
) (
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic rst,
   // Motion command and dog polarity
   input  wire logic move_en,
   input  wire logic move_dir,
   input  wire logic dog_pol,
   // Sensor pins and axis position
   output logic      dog_pin,
   output logic      z_index,
   output logic      enc_step,
   output logic      enc_down,
   output int        pos
);
   int cnt;
   // One step per STEP_CYC cycles while motion is commanded; slow against the filter
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cnt      <= 0;
         pos      <= 0;
         enc_step <= 1'b0;
      end else begin
         cnt <= (move_en && cnt < STEP_CYC - 1) ? cnt + 1 : 0;
         if (move_en && cnt == STEP_CYC - 1) begin
            pos      <= move_dir ? pos - 1 : pos + 1;
            enc_step <= 1'b1;
         end else if (cnt == STEP_CYC / 2 - 1 || !move_en) begin
            enc_step <= 1'b0;
         end
      end
   end
   // Direction held steady around every step
   assign enc_down = move_dir;
   // Index once per revolution of 16 steps, seen only by the drive
   assign z_index = (pos % 16) == 0;
   // Dog spans DOG_LO..DOG_HI; pin level follows the chosen polarity
   assign dog_pin = dog_pol ~^ (pos >= DOG_LO && pos <= DOG_HI);
endmodule // hsq_axis_model

// ### verif/testbench.sv
// Self-checking bench: APB setup, three searches, refused starts
`timescale 1ns/1ps
module testbench;
   localparam logic [31:0] HSPD = 32'h0000_0500;
   localparam logic [31:0] CSPD = 32'h0000_0040;
   localparam logic [31:0] HRMP = 32'h0000_0020;
   localparam logic [31:0] NRMP = 32'h0000_0090;
   localparam logic [31:0] HPOS = 32'h0000_1234;
   logic        ref_clk            = 1'b0;
   logic        rst                = 1'b1;
   logic        psel               = 1'b0;
   logic        penable            = 1'b0;
   logic        pwrite             = 1'b0;
   logic [7:0]  paddr              = 8'h00;
   logic [31:0] pwdata             = 32'h0000_0000;
   logic        auto_manual_select = 1'b0;
   logic [2:0]  tbl                = 3'h0;
   logic        start_request      = 1'b0;
   logic        dog_pol            = 1'b0;
   logic [31:0] prdata, speed_cmd, ramp_time, q;
   logic        pready, pslverr, e, dog_pin, z_index, enc_step, enc_down;
   logic        move_en, move_dir, homing_busy, home_done;
   int          pos;
   int          mismatches         = 0;
   int          check_count        = 0;

   // Clock at 4 ns
   always #2 ref_clk = ~ref_clk;

   hsq_homing_sequencer #(.TICK_CYC(10)) u_dut (
      .ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .auto_manual_select, .table_select_bit0(tbl[0]), .table_select_bit1(tbl[1]),
      .table_select_bit2(tbl[2]), .start_request, .dog_pin, .z_index, .enc_step, .enc_down,
      .move_en, .move_dir, .speed_cmd, .ramp_time, .homing_busy, .home_done);
   hsq_axis_model u_axis (.ref_clk, .rst, .move_en, .move_dir, .dog_pol, .dog_pin, .z_index,
      .enc_step, .enc_down, .pos);

   // Verdict and end of run
   task automatic tally_and_finish();
      if (mismatches == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic give_up();
      mismatches++;
      tally_and_finish();
   endtask
   task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic check_rng(input string name, input int lo, input int hi, input int got);
      check_count++;
      if (got < lo || got > hi) begin
         mismatches++;
         $display("[FAIL] %s expected %0d..%0d seen %0d", name, lo, hi, got);
      end
   endtask
   // One APB transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) give_up();
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
      apb(1'b0, a, 32'h0000_0000);
      check_val(name, exp, q);
   endtask
   // Bounded wait for creep speed or for the done flag; looked at on the falling
   // edge so the registered outputs launched at the rising edge have settled
   task automatic wait_on(input bit for_done);
      int n;
      n = 0;
      while (!(for_done ? home_done === 1'b1 : speed_cmd === CSPD)) begin
         @(negedge ref_clk);
         n++;
         if (n > 5000) give_up();
      end
   endtask
   task automatic start_pulse(input int len);
      start_request <= 1'b1;
      repeat (len) @(posedge ref_clk);
      start_request <= 1'b0;
   endtask
   // One complete search with its checks
   task automatic run_home(input logic [31:0] typ, input logic [31:0] shift,
      input logic [31:0] post, input logic prog, input int dlo, input int dhi,
      input int hlo, input int hhi);
      apb(1'b1, hsq_pkg::OFS_TYPE, typ);
      dog_pol <= typ[8];
      apb(1'b1, hsq_pkg::OFS_SHIFT, shift);
      apb(1'b1, hsq_pkg::OFS_POST_DOG, post);
      apb(1'b1, hsq_pkg::OFS_CTRL, {31'h0, prog});
      repeat (60) @(posedge ref_clk);
      if (prog) begin
         apb(1'b1, hsq_pkg::OFS_CTRL, 32'h0000_0003);
      end else begin
         start_pulse(50);
      end
      repeat (4) @(posedge ref_clk);
      check_val("speed fast", HSPD, speed_cmd);
      check_val("ramp homing", HRMP, ramp_time);
      check_val("direction", {31'h0, typ[4]}, {31'h0, move_dir});
      wait_on(1'b0);
      check_rng("dog position", dlo, dhi, pos);
      wait_on(1'b1);
      repeat (12) @(posedge ref_clk);
      check_val("flags", 32'h1, {29'h0, move_en, homing_busy, home_done});
      check_rng("home position", hlo, hhi, pos);
      check_val("ramp normal", NRMP, ramp_time);
      rd_chk(hsq_pkg::OFS_POSITION, HPOS, "position");
      rd_chk(hsq_pkg::OFS_STATUS, 32'h0000_0022, "status done");
      apb(1'b1, hsq_pkg::OFS_STATUS, 32'h0000_0002);
   endtask

   // Main sequence
   initial begin
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      rd_chk(hsq_pkg::OFS_FILTER, 32'h0000_0003, "filter reset");
      rd_chk(hsq_pkg::OFS_STATUS, 32'h0000_0000, "status reset");
      rd_chk(hsq_pkg::OFS_TYPE, 32'h0000_0000, "type reset");
      apb(1'b0, 8'h34, 32'h0000_0000);
      check_val("unmapped error", 32'h1, {31'h0, e});
      auto_manual_select <= 1'b1;
      apb(1'b1, hsq_pkg::OFS_HOME_SPEED, HSPD);
      apb(1'b1, hsq_pkg::OFS_CREEP, CSPD);
      apb(1'b1, hsq_pkg::OFS_HOME_RAMP, HRMP);
      apb(1'b1, hsq_pkg::OFS_NORM_RAMP, NRMP);
      apb(1'b1, hsq_pkg::OFS_HOME_POS, HPOS);
      run_home(32'h000, 32'h0, 32'h0, 1'b0, 40, 46, 96, 97);
      run_home(32'h111, 32'd20, 32'd20, 1'b0, 74, 80, 27, 28);
      tbl <= 3'h3;
      apb(1'b1, hsq_pkg::OFS_PROG_MASK, 32'h0000_0008);
      run_home(32'h000, 32'h0, 32'h0, 1'b1, 40, 46, 96, 97);
      tbl <= 3'h0;
      apb(1'b1, hsq_pkg::OFS_CTRL, 32'h0000_0000);
      repeat (60) @(posedge ref_clk);
      start_pulse(8);
      repeat (60) @(posedge ref_clk);
      check_val("short start", 32'h0, {31'h0, homing_busy});
      apb(1'b1, hsq_pkg::OFS_TYPE, 32'h0000_0002);
      start_pulse(50);
      repeat (10) @(posedge ref_clk);
      check_val("bad kind busy", 32'h0, {31'h0, homing_busy});
      apb(1'b0, hsq_pkg::OFS_STATUS, 32'h0000_0000);
      check_val("bad kind flag", 32'h1, {31'h0, q[6]});
      tally_and_finish();
   end
endmodule // testbench
